// ===== eepc_control.sv
// EEPROM program and erase control block with register file, latches and array model.
//
// Function
// RULE1: Registers at 0x00F0, array 0x0D00-0x0FFF.
// RULE2: Read enable off withholds array reads only.
// RULE3: Stop removes voltage, keeps bit, restores after.
// RULE4: Software picks RC pump clock below 1MHz.
// RULE5: Wait-stop bit gates module clock in wait.
// RULE6: Protect lock writable once in normal modes.
// RULE7: Pump clock select picks system or RC.
// RULE8: Protect writes need voltage and lock clear.
// RULE9: Five block bits guard five regions.
// RULE10: Test bits writable only in special modes.
// RULE11: Odd/even row test bulk-operates physical rows.
// RULE12: Test bits steer margin, pump, ramp, monitor.
// RULE13: Bulk protect blocks bulk and row erase.
// RULE14: Single and row select choose erase size.
// RULE15: Size selects ignored in program mode.
// RULE16: Single erase acts on latched byte/word.
// RULE17: Latch enable hides the array from reads.
// RULE18: Voltage sets only after latch already set.
// RULE19: Voltage freezes control bits and latches.
// RULE20: Software follows latch-write-apply-wait-clear sequence.
// RULE21: Software clears both bits before reading back.
// RULE22: Mode and latch bits accept any write order.
// RULE23: Erased bytes read as 0xFF.
// RULE24: Misaligned word latches only lower byte.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module eepc_control #(
    parameter int ARRAY_BYTES = eepc_pkg::ARRAY_BYTES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic word_access,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [15:0] rdata,
    output logic read_hit,
    input wire logic array_read_enable,
    input wire logic special_mode_n,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic pump_voltage_on,
    output logic rc_osc_enable,
    output logic pump_clock_from_rc,
    output logic voltage_headroom_test,
    output logic pump_disable,
    output logic pump_ramp_disable,
    output logic pump_monitor_out
);
    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [7:0] mem_q [ARRAY_BYTES];
    logic [7:0] config_q, config_d;
    logic [7:0] protect_q, protect_d;
    logic [7:0] test_q, test_d;
    logic [7:0] prog_q, prog_d;
    logic lock_written_q, lock_written_d;
    logic [9:0] lat_addr_q, lat_addr_d;
    logic [15:0] lat_data_q, lat_data_d;
    logic lat_word_q, lat_word_d;
    logic lat_valid_q, lat_valid_d;
    logic [15:0] rdata_q, rdata_d;
    logic read_hit_q, read_hit_d;
    logic pgm_q;
    logic wait_s, stop_s, special_n_s;
    logic module_clocked;
    logic [15:0] arr_ofs;
    logic [9:0] ofs;
    logic in_regs, in_array;
    logic prot_lo, prot_hi;

    // Mode pins come from outside the clock domain.
    eepc_sync u_sync_wait (.clock(clock), .rst_n(rst_n), .d(wait_mode), .q(wait_s));
    eepc_sync u_sync_stop (.clock(clock), .rst_n(rst_n), .d(stop_mode), .q(stop_s));
    eepc_sync u_sync_smod (.clock(clock), .rst_n(rst_n), .d(special_mode_n), .q(special_n_s));

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Fixed windows; remapping is absent.
    assign in_regs = (addr[15:2] == eepc_pkg::REG_BASE[15:2]); // [RULE1]
    assign in_array = (addr >= eepc_pkg::ARRAY_FIRST) && (addr <= eepc_pkg::ARRAY_LAST); // [RULE1]
    assign arr_ofs = addr - eepc_pkg::ARRAY_FIRST;
    assign ofs = arr_ofs[9:0];
    // Wait-stop plus wait mode freezes register writes, latches and array updates; reads still answer.
    assign module_clocked = !(wait_s && config_q[eepc_pkg::MC_WAIT_STOP]); // [RULE5]

    eepc_protect_map u_prot_lo (
        .offset(lat_addr_q),
        .block_protect_bits(protect_q[4:0]),
        .protected_o(prot_lo)
    );
    eepc_protect_map u_prot_hi (
        .offset(lat_addr_q | 10'h001),
        .block_protect_bits(protect_q[4:0]),
        .protected_o(prot_hi)
    );

    // True if the physical row is in the active row test set.
    function automatic logic row_selected(input logic [9:0] o, input logic [7:0] t);
        logic odd_row;
        odd_row = o[5];
        row_selected = (odd_row && t[eepc_pkg::TC_ODD_ROW]) || (!odd_row && t[eepc_pkg::TC_EVEN_ROW]); // [RULE11]
    endfunction

    // ----------------------------------------------------------------
    // Register writes and latches
    // ----------------------------------------------------------------
    // Control bits follow the interlocks; a frozen bit keeps its value.
    always_comb begin
        config_d = config_q;
        protect_d = protect_q;
        test_d = test_q;
        prog_d = prog_q;
        lock_written_d = lock_written_q;
        lat_addr_d = lat_addr_q;
        lat_data_d = lat_data_q;
        lat_word_d = lat_word_q;
        lat_valid_d = lat_valid_q;
        if (special_n_s) begin
            test_d = eepc_pkg::TC_RESET; // [RULE10]
        end
        if (write_strobe && module_clocked && in_regs) begin
            case (addr)
                eepc_pkg::OFS_MODULE_CONFIG: begin
                    config_d[eepc_pkg::MC_WAIT_STOP] = wdata[eepc_pkg::MC_WAIT_STOP];
                    config_d[eepc_pkg::MC_PUMP_CLOCK_SEL] = wdata[eepc_pkg::MC_PUMP_CLOCK_SEL]; // [RULE7]
                    if (!special_n_s || !lock_written_q) begin
                        config_d[eepc_pkg::MC_PROTECT_LOCK] = wdata[eepc_pkg::MC_PROTECT_LOCK]; // [RULE6]
                        lock_written_d = special_n_s;
                    end
                end
                eepc_pkg::OFS_BLOCK_PROTECT: begin
                    if (!prog_q[eepc_pkg::PC_VOLTAGE] && !config_q[eepc_pkg::MC_PROTECT_LOCK]) begin
                        protect_d = {3'h0, wdata[4:0] & eepc_pkg::BP_MASK}; // [RULE8] [RULE6]
                    end
                end
                eepc_pkg::OFS_TEST_CONTROL: begin
                    if (!special_n_s) begin
                        test_d = wdata[7:0] & eepc_pkg::TC_MASK; // [RULE10]
                    end
                end
                eepc_pkg::OFS_PROGRAM_CONTROL: begin
                    if (!prog_q[eepc_pkg::PC_VOLTAGE]) begin
                        // Bits land independently, so any order works.
                        prog_d[eepc_pkg::PC_SINGLE] = wdata[eepc_pkg::PC_SINGLE]; // [RULE22] [RULE19]
                        prog_d[eepc_pkg::PC_ROW] = wdata[eepc_pkg::PC_ROW]; // [RULE22]
                        prog_d[eepc_pkg::PC_ERASE] = wdata[eepc_pkg::PC_ERASE]; // [RULE22]
                        prog_d[eepc_pkg::PC_LATCH] = wdata[eepc_pkg::PC_LATCH]; // [RULE22]
                        if (!config_q[eepc_pkg::MC_PROTECT_LOCK]) begin
                            prog_d[eepc_pkg::PC_BULK_PROTECT] = wdata[eepc_pkg::PC_BULK_PROTECT]; // [RULE8]
                        end
                        // Voltage needs the latch set beforehand.
                        prog_d[eepc_pkg::PC_VOLTAGE] = wdata[eepc_pkg::PC_VOLTAGE] && prog_q[eepc_pkg::PC_LATCH]; // [RULE18]
                    end else begin
                        prog_d[eepc_pkg::PC_VOLTAGE] = wdata[eepc_pkg::PC_VOLTAGE];
                        prog_d[eepc_pkg::PC_LATCH] = wdata[eepc_pkg::PC_LATCH] || wdata[eepc_pkg::PC_VOLTAGE]; // [RULE19]
                    end
                end
                default: begin
                end
            endcase
        end
        // Array writes with latch set capture target; frozen while voltage applies.
        if (write_strobe && module_clocked && in_array && prog_q[eepc_pkg::PC_LATCH]
                && !prog_q[eepc_pkg::PC_VOLTAGE]) begin // [RULE19]
            lat_addr_d = ofs;
            lat_data_d = wdata;
            lat_word_d = word_access && !ofs[0]; // [RULE24]
            lat_valid_d = 1'b1;
        end
        if (!prog_d[eepc_pkg::PC_LATCH]) begin
            lat_valid_d = 1'b0;
        end
    end

    // Control registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= eepc_pkg::MC_RESET;
            protect_q <= eepc_pkg::BP_RESET;
            test_q <= eepc_pkg::TC_RESET;
            prog_q <= eepc_pkg::PC_RESET; // [RULE13]
            lock_written_q <= 1'b0;
            lat_addr_q <= 10'h000;
            lat_data_q <= 16'h0000;
            lat_word_q <= 1'b0;
            lat_valid_q <= 1'b0;
        end else begin
            config_q <= config_d;
            protect_q <= protect_d;
            test_q <= test_d;
            prog_q <= prog_d;
            lock_written_q <= lock_written_d;
            lat_addr_q <= lat_addr_d;
            lat_data_q <= lat_data_d;
            lat_word_q <= lat_word_d;
            lat_valid_q <= lat_valid_d;
        end
    end

    // ----------------------------------------------------------------
    // Array cell update
    // ----------------------------------------------------------------
    // Cells act once, as voltage rises; real timing is up to software.
    // Programming clears bits only, as a real cell can.
    always_ff @(posedge clock) begin
        if (module_clocked && pump_voltage_on && !pgm_q && lat_valid_q) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                logic [9:0] io;
                logic blk;
                io = 10'(i);
                blk = (io < 10'h100) ? protect_q[4] : (io < 10'h200) ? protect_q[3] :
                      (io < 10'h280) ? protect_q[2] : (io < 10'h2c0) ? protect_q[1] : protect_q[0]; // [RULE9]
                if (!blk) begin
                    if (test_q[eepc_pkg::TC_ODD_ROW] || test_q[eepc_pkg::TC_EVEN_ROW]) begin
                        if (row_selected(io, test_q)) begin
                            mem_q[i] <= prog_q[eepc_pkg::PC_ERASE] ? eepc_pkg::ERASED_BYTE
                                                                  : (mem_q[i] & lat_data_q[7:0]); // [RULE11]
                        end
                    end else if (prog_q[eepc_pkg::PC_ERASE] && !prog_q[eepc_pkg::PC_SINGLE]) begin // [RULE15]
                        if (!prog_q[eepc_pkg::PC_BULK_PROTECT]) begin // [RULE13]
                            if (!prog_q[eepc_pkg::PC_ROW] || io[9:5] == lat_addr_q[9:5]) begin
                                mem_q[i] <= eepc_pkg::ERASED_BYTE; // [RULE14] [RULE23]
                            end
                        end
                    end
                end
            end
            // Single location: latched byte or aligned word.
            if (!(test_q[eepc_pkg::TC_ODD_ROW] || test_q[eepc_pkg::TC_EVEN_ROW])
                    && (!prog_q[eepc_pkg::PC_ERASE] || prog_q[eepc_pkg::PC_SINGLE])) begin // [RULE16]
                if (!prot_lo) begin
                    mem_q[lat_addr_q] <= prog_q[eepc_pkg::PC_ERASE] ? eepc_pkg::ERASED_BYTE
                        : (mem_q[lat_addr_q] & (lat_word_q ? lat_data_q[15:8] : lat_data_q[7:0]));
                end
                if (lat_word_q && !prot_hi) begin
                    mem_q[lat_addr_q | 10'h001] <= prog_q[eepc_pkg::PC_ERASE] ? eepc_pkg::ERASED_BYTE
                        : (mem_q[lat_addr_q | 10'h001] & lat_data_q[7:0]); // [RULE24]
                end
            end
        end
    end

    // Edge history of the applied voltage so each rise acts once.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pgm_q <= 1'b0;
        end else if (module_clocked) begin
            pgm_q <= pump_voltage_on;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Hidden array reads give way to lower-priority resources.
    always_comb begin
        rdata_d = 16'h0000;
        read_hit_d = 1'b0;
        if (read_strobe && in_regs) begin
            read_hit_d = 1'b1; // [RULE2]
            case (addr)
                eepc_pkg::OFS_MODULE_CONFIG: rdata_d = {8'h00, config_q};
                eepc_pkg::OFS_BLOCK_PROTECT: rdata_d = {8'h00, protect_q};
                eepc_pkg::OFS_TEST_CONTROL: rdata_d = {8'h00, test_q};
                eepc_pkg::OFS_PROGRAM_CONTROL: rdata_d = {8'h00, prog_q & eepc_pkg::PC_MASK};
                default: rdata_d = 16'h0000;
            endcase
        end else if (read_strobe && in_array && array_read_enable && !prog_q[eepc_pkg::PC_LATCH]) begin // [RULE2] [RULE17]
            read_hit_d = 1'b1;
            rdata_d[7:0] = mem_q[ofs];
            if (word_access && ofs < 10'(ARRAY_BYTES - 1)) begin
                rdata_d = {mem_q[ofs], mem_q[ofs + 10'h001]};
            end
        end
    end

    // Read answer stands for one cycle only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            read_hit_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            read_hit_q <= read_hit_d;
        end
    end
    assign rdata = rdata_q;
    assign read_hit = read_hit_q;

    // ----------------------------------------------------------------
    // Pump and test outputs
    // ----------------------------------------------------------------
    // Stop drops voltage and the RC clock but leaves the bit, so exit restores it.
    assign pump_voltage_on = prog_q[eepc_pkg::PC_VOLTAGE] && !stop_s; // [RULE3]
    assign pump_clock_from_rc = config_q[eepc_pkg::MC_PUMP_CLOCK_SEL]; // [RULE7] [RULE4]
    assign rc_osc_enable = config_q[eepc_pkg::MC_PUMP_CLOCK_SEL] && !stop_s; // [RULE7] [RULE3]
    assign voltage_headroom_test = test_q[eepc_pkg::TC_HEADROOM]; // [RULE12]
    assign pump_disable = test_q[eepc_pkg::TC_PUMP_DISABLE]; // [RULE12]
    assign pump_ramp_disable = test_q[eepc_pkg::TC_RAMP_DISABLE]; // [RULE12]
    assign pump_monitor_out = test_q[eepc_pkg::TC_PUMP_MONITOR]; // [RULE12]
endmodule
`default_nettype wire

// ===== eepc_pkg.sv
// Register map, fields, reset values and array layout of the EEPROM control block.
`default_nettype none
package eepc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] REG_BASE = 16'h00f0;
    localparam logic [15:0] OFS_MODULE_CONFIG = 16'h00f0;
    localparam logic [15:0] OFS_BLOCK_PROTECT = 16'h00f1;
    localparam logic [15:0] OFS_TEST_CONTROL = 16'h00f2;
    localparam logic [15:0] OFS_PROGRAM_CONTROL = 16'h00f3;
    localparam logic [15:0] ARRAY_FIRST = 16'h0d00;
    localparam logic [15:0] ARRAY_LAST = 16'h0fff;
    // ----------------------------------------------------------------
    // Module configuration fields
    // ----------------------------------------------------------------
    localparam int MC_WAIT_STOP = 2;
    localparam int MC_PROTECT_LOCK = 1;
    localparam int MC_PUMP_CLOCK_SEL = 0;
    localparam logic [7:0] MC_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Block protect fields
    // ----------------------------------------------------------------
    localparam logic [7:0] BP_RESET = 8'h1f;
    localparam logic [4:0] BP_MASK = 5'h1f;
    // ----------------------------------------------------------------
    // Test control fields
    // ----------------------------------------------------------------
    localparam int TC_ODD_ROW = 7;
    localparam int TC_EVEN_ROW = 6;
    localparam int TC_HEADROOM = 5;
    localparam int TC_PUMP_DISABLE = 3;
    localparam int TC_RAMP_DISABLE = 2;
    localparam int TC_PUMP_MONITOR = 1;
    localparam logic [7:0] TC_MASK = 8'hee;
    localparam logic [7:0] TC_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Program control fields
    // ----------------------------------------------------------------
    localparam int PC_BULK_PROTECT = 7;
    localparam int PC_SINGLE = 4;
    localparam int PC_ROW = 3;
    localparam int PC_ERASE = 2;
    localparam int PC_LATCH = 1;
    localparam int PC_VOLTAGE = 0;
    localparam logic [7:0] PC_RESET = 8'h80;
    localparam logic [7:0] PC_MASK = 8'h9f;
    // ----------------------------------------------------------------
    // Array contents
    // ----------------------------------------------------------------
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int ROW_BYTES = 32;
    localparam int ARRAY_BYTES = 768;
endpackage
`default_nettype wire

// ===== eepc_protect_map.sv
// Block protection lookup for one array byte offset.
`default_nettype none
module eepc_protect_map (
    input wire logic [9:0] offset,
    input wire logic [4:0] block_protect_bits,
    output logic protected_o
);
    // ----------------------------------------------------------------
    // Region decode
    // ----------------------------------------------------------------
    // Offsets 0x000..0x2ff map onto the five protected regions.
    always_comb begin
        if (offset < 10'h100) begin
            protected_o = block_protect_bits[4]; // [RULE9]
        end else if (offset < 10'h200) begin
            protected_o = block_protect_bits[3]; // [RULE9]
        end else if (offset < 10'h280) begin
            protected_o = block_protect_bits[2]; // [RULE9]
        end else if (offset < 10'h2c0) begin
            protected_o = block_protect_bits[1]; // [RULE9]
        end else begin
            protected_o = block_protect_bits[0]; // [RULE9]
        end
    end
endmodule
`default_nettype wire

// ===== eepc_sync.sv
// Two flip-flop synchroniser for a level from another domain.
`default_nettype none
module eepc_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic sync_q;
    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    // Only the second stage is seen by other logic.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
    assign q = sync_q;
endmodule
`default_nettype wire

// ===== eepc_control_properties.sv
// Port-level checker of the EEPROM control block.
`default_nettype none
module eepc_control_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [15:0] rdata,
    input wire logic read_hit,
    input wire logic special_mode_n,
    input wire logic stop_mode,
    input wire logic pump_voltage_on,
    input wire logic rc_osc_enable,
    input wire logic pump_clock_from_rc,
    input wire logic voltage_headroom_test,
    input wire logic pump_disable,
    input wire logic pump_ramp_disable,
    input wire logic pump_monitor_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Read data is zero outside the cycle after a read.
    a_rdata_idle: assert property (!$past(read_strobe) |-> rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_hit_cause: assert property (read_hit |-> $past(read_strobe))
        else $error("read hit without a read");
    a_reg_hit: assert property (read_strobe && addr[15:2] == 14'h003c |=> read_hit)
        else $error("register read not answered");
    // Stop passes two flops, so three stop samples must remove voltage and oscillator.
    a_stop_off: assert property (stop_mode [*3] |-> !pump_voltage_on && !rc_osc_enable)
        else $error("pump active in stop");
    a_rc_select: assert property (rc_osc_enable |-> pump_clock_from_rc)
        else $error("oscillator on with system clock");
    a_volt_rise: assert property ($rose(pump_voltage_on) |-> ($past(write_strobe) && $past(addr) == 16'h00f3
        && $past(wdata[0])) || $past(stop_mode, 2) || $past(stop_mode, 3))
        else $error("voltage rose without cause");
    a_volt_clear: assert property (write_strobe && addr == 16'h00f3 && !wdata[0] |=> !pump_voltage_on)
        else $error("voltage not removed");
    a_test_normal: assert property (special_mode_n [*4] |-> !voltage_headroom_test && !pump_disable
        && !pump_ramp_disable && !pump_monitor_out)
        else $error("test outputs active in normal mode");
    c_read: cover property (read_hit);
    c_volt: cover property ($rose(pump_voltage_on));
    c_stop: cover property (stop_mode && pump_voltage_on);
    c_test: cover property (!special_mode_n && pump_disable);
endmodule
bind eepc_control eepc_control_properties eepc_control_properties_i (.clock, .rst_n, .addr, .wdata,
    .write_strobe, .read_strobe, .rdata, .read_hit, .special_mode_n, .stop_mode, .pump_voltage_on,
    .rc_osc_enable, .pump_clock_from_rc, .voltage_headroom_test, .pump_disable, .pump_ramp_disable,
    .pump_monitor_out);
`default_nettype wire

// ===== eepc_cpu_model.sv
// Processor core model on the internal bus.
`default_nettype none
module eepc_cpu_model (
    input wire logic clock,
    input wire logic [15:0] rdata,
    input wire logic read_hit,
    output logic [15:0] addr,
    output logic [15:0] wdata,
    output logic word_access,
    output logic write_strobe,
    output logic read_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle from time zero.
    initial {addr, wdata, word_access, write_strobe, read_strobe} = 35'h0;
    // Released address and data lines show the inverse of their last value; strobes go low.
    task automatic release_bus;
        write_strobe <= 1'b0;
        read_strobe <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
        #1;
    endtask
    // One-cycle write; the slave never stalls.
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        word_access <= w;
        write_strobe <= 1'b1;
        @(posedge clock);
        release_bus();
    endtask
    // Read; the answer is taken in the cycle after the strobe.
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic h);
        @(posedge clock);
        addr <= a;
        word_access <= 1'b0;
        read_strobe <= 1'b1;
        @(posedge clock);
        release_bus();
        d = rdata;
        h = read_hit;
    endtask
endmodule
`default_nettype wire

// ===== eepc_control_tb.sv
// Self-checking bench of the EEPROM control block.
`default_nettype none
module eepc_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MC = eepc_pkg::OFS_MODULE_CONFIG, BP = eepc_pkg::OFS_BLOCK_PROTECT;
    localparam logic [15:0] TC = eepc_pkg::OFS_TEST_CONTROL, PC = eepc_pkg::OFS_PROGRAM_CONTROL;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic array_read_enable = 1'b1;
    logic special_mode_n = 1'b1;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic [15:0] addr, wdata, rdata;
    logic word_access, write_strobe, read_strobe, read_hit, pump_voltage_on, rc_osc_enable;
    logic pump_clock_from_rc, voltage_headroom_test, pump_disable, pump_ramp_disable, pump_monitor_out;
    int num_errors = 0;
    int comparisons = 0;
    logic [7:0] rst_vals [4] = '{8'h00, 8'h1f, 8'h00, 8'h80};
    logic [7:0] bulk_modes [2] = '{8'h84, 8'h8c};
    // Clock at 40 MHz.
    always #12.5 clock = ~clock;
    eepc_control eepc_control_i (.clock, .rst_n, .addr, .wdata, .word_access, .write_strobe, .read_strobe,
        .rdata, .read_hit, .array_read_enable, .special_mode_n, .wait_mode, .stop_mode, .pump_voltage_on,
        .rc_osc_enable, .pump_clock_from_rc, .voltage_headroom_test, .pump_disable, .pump_ramp_disable,
        .pump_monitor_out);
    eepc_cpu_model eepc_cpu_model_i (.clock, .rdata, .read_hit, .addr, .wdata, .word_access, .write_strobe,
        .read_strobe);
    task automatic wrap_up;
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Byte read against expected data and hit.
    task automatic rb(input logic [15:0] a, input logic [7:0] e, input logic eh);
        logic [15:0] d;
        logic h;
        eepc_cpu_model_i.rd(a, d, h);
        chk(d, {8'h00, e});
        chk(16'(h), 16'(eh));
    endtask
    task automatic wb(input logic [15:0] a, input logic [7:0] d);
        eepc_cpu_model_i.wr(a, {8'h00, d}, 1'b0);
    endtask
    // Latch, write, apply voltage, wait, clear.
    task automatic op(input logic [15:0] a, input logic [15:0] d, input logic w, input logic [7:0] m);
        wb(PC, m | 8'h02);
        eepc_cpu_model_i.wr(a, d, w);
        wb(PC, m | 8'h03);
        repeat (4) @(posedge clock);
        wb(PC, 8'h00);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    // Hang guard; tests need under 1000 cycles.
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        wrap_up();
    end
    // Bus clock is 40 MHz, so the system clock may drive the pump.
    initial begin
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rb(MC + 16'(i), rst_vals[i], 1'b1);
        end
        rb(16'h00f4, 8'h00, 1'b0);
        wb(TC, 8'hee);
        rb(TC, 8'h00, 1'b1);
        wb(BP, 8'h00);
        rb(BP, 8'h00, 1'b1);
        op(16'h0d00, 16'h0000, 1'b0, 8'h14);
        rb(16'h0d00, eepc_pkg::ERASED_BYTE, 1'b1);
        op(16'h0d00, 16'h00a5, 1'b0, 8'h18);
        rb(16'h0d00, 8'ha5, 1'b1);
        op(16'h0d02, 16'h0000, 1'b1, 8'h14);
        op(16'h0d02, 16'h1234, 1'b1, 8'h00);
        rb(16'h0d02, 8'h12, 1'b1);
        rb(16'h0d03, 8'h34, 1'b1);
        wb(BP, 8'h10);
        op(16'h0d00, 16'h0000, 1'b0, 8'h00);
        rb(16'h0d00, 8'ha5, 1'b1);
        wb(BP, 8'h08);
        op(16'h0d00, 16'h0000, 1'b0, 8'h00);
        rb(16'h0d00, 8'h00, 1'b1);
        foreach (bulk_modes[i]) begin
            op(16'h0d00, 16'h0000, 1'b0, bulk_modes[i]);
            rb(16'h0d00, 8'h00, 1'b1);
        end
        wb(PC, 8'h02);
        rb(16'h0d00, 8'h00, 1'b0);
        wb(PC, 8'h00);
        array_read_enable <= 1'b0;
        repeat (3) @(posedge clock);
        rb(16'h0d00, 8'h00, 1'b0);
        rb(BP, 8'h08, 1'b1);
        array_read_enable <= 1'b1;
        wb(PC, 8'h03);
        rb(PC, 8'h02, 1'b1);
        chk(16'(pump_voltage_on), 16'h0000);
        wb(PC, 8'h03);
        chk(16'(pump_voltage_on), 16'h0001);
        wb(PC, 8'h95);
        rb(PC, 8'h03, 1'b1);
        wb(BP, 8'h1f);
        rb(BP, 8'h08, 1'b1);
        stop_mode <= 1'b1;
        repeat (4) @(posedge clock);
        chk(16'(pump_voltage_on), 16'h0000);
        stop_mode <= 1'b0;
        repeat (4) @(posedge clock);
        chk(16'(pump_voltage_on), 16'h0001);
        rb(PC, 8'h03, 1'b1);
        wb(PC, 8'h00);
        special_mode_n <= 1'b0;
        repeat (3) @(posedge clock);
        wb(TC, 8'hee);
        rb(TC, 8'hee, 1'b1);
        chk({12'h000, voltage_headroom_test, pump_disable, pump_ramp_disable, pump_monitor_out}, 16'h000f);
        wb(TC, 8'h80);
        op(16'h0d20, 16'h0000, 1'b0, 8'h00);
        wb(TC, 8'h00);
        rb(16'h0d20, 8'h00, 1'b1);
        rb(16'h0d02, 8'h12, 1'b1);
        wb(MC, 8'h01);
        chk({14'h0000, pump_clock_from_rc, rc_osc_enable}, 16'h0003);
        wb(MC, 8'h02);
        wb(MC, 8'h00);
        rb(MC, 8'h00, 1'b1);
        chk(16'(rc_osc_enable), 16'h0000);
        wb(MC, 8'h04);
        wait_mode <= 1'b1;
        repeat (2) @(posedge clock);
        wb(MC, 8'h00);
        rb(MC, 8'h04, 1'b1);
        special_mode_n <= 1'b1;
        do_reset();
        wb(MC, 8'h02);
        wb(MC, 8'h00);
        rb(MC, 8'h02, 1'b1);
        wb(BP, 8'h00);
        rb(BP, 8'h1f, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
